/* hdl/eta_defines.svh */
// Shared constants of the transmit egress arbiter and its MAC-side partner.
`ifndef ETA_DEFINES_SVH
`define ETA_DEFINES_SVH

// ==========================================================================
// Response packets
`define ETA_RESP_BITS 120
`define ETA_RESP_WORD_BYTES 15
`define ETA_RESP_LEN 60
// ==========================================================================
// Stream packets
`define ETA_STRM_LEN 557
`define ETA_STRM_HDR_LEN 3
`define ETA_STRM_SAMPLES 277
`define ETA_STRM_GROUP 4
`define ETA_STRM_HDR_MARK 8'hAA
`define ETA_STRM_HDR_PAD 8'h00
`define ETA_STRM_PAUSE_CYC 16
`define ETA_SAMPLE_BITS 16
`define ETA_FIFO_AW 10
// ==========================================================================
// Flag positions
`define ETA_FLAG_FULL 1
`define ETA_FLAG_EMPTY 0

`endif

/* hdl/eta_pkg.sv */
// Types shared by both ends of the transmit egress link.
`default_nettype none

package eta_pkg;

  // Arbiter states; 2'b11 is the undefined encoding.
  typedef enum logic [1:0] {
    ARB_IDLE = 2'b00,
    ARB_RESP = 2'b01,
    ARB_STRM = 2'b10
  } eta_arb_e;

  typedef logic [7:0] eta_byte_t;

endpackage : eta_pkg

`default_nettype wire

/* hdl/eta_tx_if.sv */
// Byte-wide frame link between the egress arbiter and the MAC client.
`default_nettype none

interface eta_tx_if;
  import eta_pkg::*;

  eta_byte_t tx_byte_out;
  logic tx_frame_start;
  logic tx_frame_end;
  logic tx_src_valid_n;
  logic mac_dest_ready_n;

  // The arbiter end drives frames; the MAC end drives back-pressure.
  modport source (
    output tx_byte_out,
    output tx_frame_start,
    output tx_frame_end,
    output tx_src_valid_n,
    input mac_dest_ready_n
  );

  modport mac (
    input tx_byte_out,
    input tx_frame_start,
    input tx_frame_end,
    input tx_src_valid_n,
    output mac_dest_ready_n
  );

endinterface : eta_tx_if

`default_nettype wire

/* hdl/eta_mac_sink.sv */
// MAC transmit client end: accepts frame bytes and applies back-pressure.
`default_nettype none
`include "eta_defines.svh"

module eta_mac_sink
  import eta_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  eta_tx_if.mac link,
  input wire logic accept_stall,
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_frame_start,
  output logic rx_frame_end,
  output logic [15:0] frame_count,
  output logic [15:0] last_frame_len
);

  typedef struct packed {
    logic rdy;
    logic [7:0] data;
    logic valid;
    logic sof;
    logic eof;
    logic [15:0] frames;
    logic [15:0] len;
    logic [15:0] last_len;
  } eta_sink_s;

  eta_sink_s s;
  eta_sink_s next_s;
  logic take;

  // ==========================================================================
  // Acceptance
  // Ready is high (ready_n low) whenever the user does not stall; it is registered, so a
  // stall takes effect one cycle late and the arbiter simply holds its byte.
  always_comb
  begin
    next_s = s;
    take = !link.tx_src_valid_n && s.rdy;
    next_s.rdy = !accept_stall;
    next_s.valid = take;
    next_s.sof = take && link.tx_frame_start;
    next_s.eof = take && link.tx_frame_end;
    if (take)
    begin
      next_s.data = link.tx_byte_out;
      next_s.len = link.tx_frame_start ? 16'h0001 : s.len + 16'h0001;
      if (link.tx_frame_end)
      begin
        next_s.frames = s.frames + 16'h0001;
        next_s.last_len = link.tx_frame_start ? 16'h0001 :
                          s.len + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign link.mac_dest_ready_n = ~s.rdy;
  assign rx_byte = s.data;
  assign rx_byte_valid = s.valid;
  assign rx_frame_start = s.sof;
  assign rx_frame_end = s.eof;
  assign frame_count = s.frames;
  assign last_frame_len = s.last_len;

endmodule : eta_mac_sink

`default_nettype wire

/* hdl/eta_egress_arbiter.sv */
// Egress arbiter: response and stream packetizers sharing one transmit port.
// How it works
// - One state machine shares port between traffic kinds.
// - Waveform rate arrives as an enable on clk.
// - Samples enter stream packetizer through sample FIFO.
// - Responses win; stream grant sends four 557-byte packets.
// - Idle until response or stream pending rises.
// - Leave idle only while MAC ready_n is low.
// - Both pending together: response goes first.
// - Response packet is sixty bytes long.
// - Response grant enters response-read state, asserts grant.
// - Response done returns response-read state to idle.
// - Group done pulses after four stream packets.
// - Each source gives byte, start, end, valid flags.
// - Stream grant enters stream-read state until group done.
// - Stream source pauses after each group.
// - Grants choose which source feeds output lines.
// - Sticky illegal and FIFO flags, cleared by flag_clear.
`default_nettype none
`include "eta_defines.svh"

module eta_egress_arbiter
  import eta_pkg::*;
#(
  parameter int FIFO_AW = `ETA_FIFO_AW
)
(
  input wire logic clk,
  input wire logic rst_n,
  eta_tx_if.source link,
  input wire logic resp_request,
  input wire logic [`ETA_RESP_BITS-1:0] resp_word,
  output logic resp_busy,
  input wire logic stream_enable,
  input wire logic sample_strobe,
  input wire logic [`ETA_SAMPLE_BITS-1:0] sample_in,
  input wire logic flag_clear,
  output logic response_grant,
  output logic stream_grant,
  output logic stream_group_done,
  output logic illegal_state_flag,
  output logic [1:0] fifo_level_flags
);

  localparam logic [FIFO_AW:0] FIFO_DEPTH = (FIFO_AW+1)'(2 ** FIFO_AW);
  localparam logic [FIFO_AW:0] PKT_SAMPLES = (FIFO_AW+1)'(`ETA_STRM_SAMPLES);
  localparam logic [5:0] RESP_LAST = 6'(`ETA_RESP_LEN - 1);
  localparam logic [5:0] RESP_WORD_BYTES = 6'(`ETA_RESP_WORD_BYTES);
  localparam logic [9:0] STRM_LAST = 10'(`ETA_STRM_LEN - 1);
  localparam logic [9:0] STRM_HDR = 10'(`ETA_STRM_HDR_LEN);
  localparam logic [1:0] GROUP_LAST = 2'(`ETA_STRM_GROUP - 1);
  localparam logic [4:0] PAUSE = 5'(`ETA_STRM_PAUSE_CYC);

  // A packet must fit in the FIFO or the stream side would wait forever.
  if (2 ** FIFO_AW < `ETA_STRM_SAMPLES || FIFO_AW > 15)
  begin : g_bad_depth
    $error("FIFO_AW cannot hold one stream packet of samples");
  end

  typedef struct packed {
    eta_arb_e arb;
    logic resp_pend;
    logic [`ETA_RESP_BITS-1:0] resp_word;
    logic [5:0] resp_idx;
    logic resp_done;
    logic [9:0] strm_idx;
    logic [1:0] strm_pkt;
    logic [7:0] strm_seq;
    logic strm_done;
    logic [4:0] pause;
    logic [FIFO_AW:0] wr;
    logic [FIFO_AW:0] rd;
    logic [7:0] out_byte;
    logic out_sof;
    logic out_eof;
    logic out_valid;
    logic illegal;
    logic [1:0] fifo_flags;
  } eta_dev_s;

  eta_dev_s s;
  eta_dev_s next_s;
  logic [`ETA_SAMPLE_BITS-1:0] sample_mem [2 ** FIFO_AW];
  logic fifo_push;
  logic [`ETA_SAMPLE_BITS-1:0] head;

  // ==========================================================================
  // Sample memory
  // Written in its own process so the array stays out of the state record.
  always_ff @(posedge clk)
  begin
    if (fifo_push)
      sample_mem[s.wr[FIFO_AW-1:0]] <= sample_in;
  end

  assign head = sample_mem[s.rd[FIFO_AW-1:0]];

  // ==========================================================================
  // Arbiter, packetizers and output register
  always_comb
  begin
    logic [FIFO_AW:0] level;
    logic accept;
    logic can_load;
    logic stream_pending;
    logic [`ETA_RESP_BITS-1:0] shifted;
    logic [9:0] k;
    next_s = s;
    level = s.wr - s.rd;
    accept = s.out_valid && !link.mac_dest_ready_n;
    can_load = !s.out_valid || accept;
    shifted = s.resp_word << {s.resp_idx, 3'b000};
    k = s.strm_idx - STRM_HDR;
    stream_pending = stream_enable && level >= PKT_SAMPLES &&
                     s.pause == 5'h00;
    fifo_push = 1'b0;
    next_s.resp_done = 1'b0;
    next_s.strm_done = 1'b0;
    if (s.pause != 5'h00)
      next_s.pause = s.pause - 5'h01;

    // Response request is taken only when no response is outstanding.
    if (resp_request && !s.resp_pend)
    begin
      next_s.resp_pend = 1'b1;
      next_s.resp_word = resp_word;
    end

    // Samples at the waveform rate; a full FIFO drops the sample.
    if (sample_strobe && stream_enable)
    begin
      if (level == FIFO_DEPTH)
        next_s.fifo_flags[`ETA_FLAG_FULL] = 1'b1;
      else
      begin
        fifo_push = 1'b1;
        next_s.wr = s.wr + 1'b1;
      end
    end

    // Grant state machine; pending inputs are only looked at in idle.
    case (s.arb)
      ARB_IDLE:
      begin
        if (!link.mac_dest_ready_n)
        begin
          if (s.resp_pend)
            next_s.arb = ARB_RESP;
          else if (stream_pending)
            next_s.arb = ARB_STRM;
        end
      end
      ARB_RESP:
      begin
        if (s.resp_done)
          next_s.arb = ARB_IDLE;
      end
      ARB_STRM:
      begin
        if (s.strm_done)
          next_s.arb = ARB_IDLE;
      end
      default:
      begin
        next_s.arb = ARB_IDLE;
        next_s.illegal = 1'b1;
      end
    endcase

    // Output register drops valid once the MAC has taken the byte.
    if (accept)
      next_s.out_valid = 1'b0;

    // The grant selects which packetizer may load the output lines.
    if (s.arb == ARB_RESP && !s.resp_done && can_load)
    begin
      next_s.out_valid = 1'b1;
      next_s.out_sof = s.resp_idx == 6'h00;
      next_s.out_eof = s.resp_idx == RESP_LAST;
      next_s.out_byte = s.resp_idx < RESP_WORD_BYTES ?
                        shifted[`ETA_RESP_BITS-1 -: 8] : 8'h00;
      if (s.resp_idx == RESP_LAST)
      begin
        next_s.resp_idx = 6'h00;
        next_s.resp_done = 1'b1;
        next_s.resp_pend = 1'b0;
      end
      else
        next_s.resp_idx = s.resp_idx + 6'h01;
    end
    else if (s.arb == ARB_STRM && !s.strm_done && can_load &&
             (s.strm_idx != 10'h000 || level >= PKT_SAMPLES))
    begin
      next_s.out_valid = 1'b1;
      next_s.out_sof = s.strm_idx == 10'h000;
      next_s.out_eof = s.strm_idx == STRM_LAST;
      if (s.strm_idx == 10'h000)
        next_s.out_byte = `ETA_STRM_HDR_MARK;
      else if (s.strm_idx == 10'h001)
        next_s.out_byte = s.strm_seq;
      else if (s.strm_idx < STRM_HDR)
        next_s.out_byte = `ETA_STRM_HDR_PAD;
      else
      begin
        // High byte first; the sample leaves the FIFO with its low byte.
        next_s.out_byte = k[0] ? head[7:0] : head[15:8];
        if (k[0])
        begin
          if (level == '0)
            next_s.fifo_flags[`ETA_FLAG_EMPTY] = 1'b1;
          else
            next_s.rd = s.rd + 1'b1;
        end
      end
      if (s.strm_idx == STRM_LAST)
      begin
        next_s.strm_idx = 10'h000;
        next_s.strm_seq = s.strm_seq + 8'h01;
        next_s.strm_pkt = s.strm_pkt + 2'b01;
        if (s.strm_pkt == GROUP_LAST)
        begin
          next_s.strm_done = 1'b1;
          next_s.pause = PAUSE;
        end
      end
      else
        next_s.strm_idx = s.strm_idx + 10'h001;
    end

    // Clear first so that an event in the same cycle still sets its flag.
    if (flag_clear)
    begin
      next_s.illegal = s.arb != ARB_IDLE && s.arb != ARB_RESP &&
                       s.arb != ARB_STRM;
      next_s.fifo_flags = 2'b00;
      if (sample_strobe && stream_enable && level == FIFO_DEPTH)
        next_s.fifo_flags[`ETA_FLAG_FULL] = 1'b1;
      if (next_s.rd == s.rd && s.arb == ARB_STRM && next_s.out_valid &&
          !s.out_valid | accept && s.strm_idx >= STRM_HDR && k[0] &&
          level == '0)
        next_s.fifo_flags[`ETA_FLAG_EMPTY] = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  // ==========================================================================
  // Outputs
  assign link.tx_byte_out = s.out_byte;
  assign link.tx_frame_start = s.out_sof;
  assign link.tx_frame_end = s.out_eof;
  assign link.tx_src_valid_n = ~s.out_valid;
  assign resp_busy = s.resp_pend;
  assign response_grant = s.arb == ARB_RESP;
  assign stream_grant = s.arb == ARB_STRM;
  assign stream_group_done = s.strm_done;
  assign illegal_state_flag = s.illegal;
  assign fifo_level_flags = s.fifo_flags;

endmodule : eta_egress_arbiter

`default_nettype wire

/* sim/eta_link_checker.sv */
// Checker for the frame link between the egress arbiter and the MAC end.
`default_nettype none

module eta_link_checker
  import eta_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire eta_byte_t tx_byte_out,
  input wire logic tx_frame_start,
  input wire logic tx_frame_end,
  input wire logic tx_src_valid_n,
  input wire logic mac_dest_ready_n,
  input wire logic response_grant,
  input wire logic stream_grant,
  input wire logic stream_group_done
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Helper counters
  logic taken;
  logic [9:0] byte_cnt;
  logic [2:0] frame_cnt;
  logic [4:0] gap_cnt;

  // A byte moves on an edge where both low-active flags are low.
  assign taken = !tx_src_valid_n && !mac_dest_ready_n;

  // Bytes are counted per frame, frames per stream grant; the frame count
  // clears while no stream grant stands, so a stale group cannot leak in.
  always_ff @(posedge clk)
  begin
    if (!rst_n || (taken && tx_frame_end))
      byte_cnt <= 10'h000;
    else if (taken)
      byte_cnt <= byte_cnt + 10'h001;
    if (!rst_n || !stream_grant)
      frame_cnt <= 3'h0;
    else if (taken && tx_frame_end)
      frame_cnt <= frame_cnt + 3'h1;
    // Cycles since the stream grant last stood; it starts saturated so the
    // first grant after reset is not mistaken for a cut pause.
    if (!rst_n)
      gap_cnt <= 5'h1F;
    else if (stream_grant)
      gap_cnt <= 5'h00;
    else if (gap_cnt != 5'h1F)
      gap_cnt <= gap_cnt + 5'h01;
  end

  // ==========================================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  reset_quiet_a: assert property (
    $rose(rst_n) |-> tx_src_valid_n && !response_grant && !stream_grant)
    else $error("link or grants active right after reset");
  one_grant_a: assert property (
    !(response_grant && stream_grant))
    else $error("both grants high together");
  byte_hold_a: assert property (
    !tx_src_valid_n && mac_dest_ready_n |=> !tx_src_valid_n &&
    $stable(tx_byte_out) && $stable(tx_frame_start) && $stable(tx_frame_end))
    else $error("offered byte changed before it was taken");
  valid_in_grant_a: assert property (
    !tx_src_valid_n |-> response_grant || stream_grant)
    else $error("byte offered with no grant");
  leave_idle_a: assert property (
    $rose(response_grant) || $rose(stream_grant) |-> !$past(mac_dest_ready_n))
    else $error("grant given while MAC not ready");
  stream_end_a: assert property (
    $fell(stream_grant) |-> $past(stream_group_done))
    else $error("stream grant dropped without group done");
  done_ends_a: assert property (
    stream_group_done |-> stream_grant ##1 !stream_grant)
    else $error("group done did not close the stream grant");
  frame_len_a: assert property (
    taken && tx_frame_end |-> byte_cnt == (stream_grant ? 10'h22C : 10'h03B))
    else $error("frame length wrong");
  group_four_a: assert property (
    $fell(stream_grant) |-> frame_cnt == 3'h4)
    else $error("stream group not four frames");
  pause_gap_a: assert property (
    $rose(stream_grant) |-> gap_cnt >= 5'h10)
    else $error("stream grant returned before the pause ended");

endmodule : eta_link_checker

`default_nettype wire

/* sim/eta_egress_arbiter_test.sv */
// Self-checking bench joining the egress arbiter to the MAC sink end.
`default_nettype none
`include "eta_defines.svh"

module eta_egress_arbiter_test;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Stimulus and observed signals
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic resp_request = 1'h0;
  logic [`ETA_RESP_BITS-1:0] resp_word = '0;
  logic stream_enable = 1'h0;
  logic sample_strobe = 1'h0;
  logic [15:0] sample_in = 16'h0000;
  logic flag_clear = 1'h0;
  logic accept_stall = 1'h0;
  logic resp_busy, response_grant, stream_grant, stream_group_done;
  logic illegal_state_flag, rx_frame_start;
  logic [1:0] fifo_level_flags;
  logic [7:0] rx_byte, first_byte;
  logic [15:0] frame_count, last_frame_len, base;
  int fails = 0;
  int samples_checked = 0;

  eta_tx_if link ();

  eta_egress_arbiter eta_egress_arbiter_i (.clk(clk), .rst_n(rst_n),
    .link(link.source), .resp_request(resp_request), .resp_word(resp_word),
    .resp_busy(resp_busy), .stream_enable(stream_enable),
    .sample_strobe(sample_strobe), .sample_in(sample_in),
    .flag_clear(flag_clear), .response_grant(response_grant),
    .stream_grant(stream_grant), .stream_group_done(stream_group_done),
    .illegal_state_flag(illegal_state_flag),
    .fifo_level_flags(fifo_level_flags));

  eta_mac_sink eta_mac_sink_i (.clk(clk), .rst_n(rst_n), .link(link.mac),
    .accept_stall(accept_stall), .rx_byte(rx_byte), .rx_byte_valid(),
    .rx_frame_start(rx_frame_start), .rx_frame_end(),
    .frame_count(frame_count), .last_frame_len(last_frame_len));

  eta_link_checker eta_link_checker_i (.clk(clk), .rst_n(rst_n),
    .tx_byte_out(link.tx_byte_out), .tx_frame_start(link.tx_frame_start),
    .tx_frame_end(link.tx_frame_end), .tx_src_valid_n(link.tx_src_valid_n),
    .mac_dest_ready_n(link.mac_dest_ready_n),
    .response_grant(response_grant), .stream_grant(stream_grant),
    .stream_group_done(stream_group_done));

  // Clock of 5 ns; samples change every cycle so packets carry fresh data.
  always #2.5 clk = ~clk;

  // Sample ramp, moved 1 ns after each edge like every other input.
  always @(posedge clk)
  begin
    #1 sample_in = sample_in + 16'h0001;
  end

  // Keep the first byte of each received frame for later comparison.
  always @(posedge clk)
  begin
    if (rx_frame_start)
      first_byte <= rx_byte;
  end

  // ==========================================================================
  // Shared tasks
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task check(input string name, input logic [15:0] exp,
    input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask : check

  // Bounded wait on the sink's frame counter, so a stuck link cannot hang.
  task wait_frames(input logic [15:0] target, input int limit);
    for (int i = 0; i < limit && frame_count !== target; i++)
      step(1);
    check("frame_count", target, frame_count);
  endtask : wait_frames

  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Scenarios
  task test_reset();
    check("grants", 16'h0, 16'({response_grant, stream_grant}));
    check("valid_n", 16'h1, 16'(link.tx_src_valid_n));
    check("flags", 16'h0, 16'({illegal_state_flag, fifo_level_flags}));
    check("ready_n", 16'h0, 16'(link.mac_dest_ready_n));
    $display("test_reset done");
  endtask : test_reset

  // A second request while one is queued must be dropped.
  task test_response();
    base = frame_count;
    resp_word = {8'h5A, 112'h1};
    resp_request = 1'h1;
    step(1);
    resp_request = 1'h0;
    step(2);
    check("resp_busy", 16'h1, 16'(resp_busy));
    resp_word = {8'hC3, 112'h0};
    resp_request = 1'h1;
    step(1);
    resp_request = 1'h0;
    wait_frames(base + 16'h1, 400);
    step(30);
    check("frame_count", base + 16'h1, frame_count);
    check("last_frame_len", 16'h003C, last_frame_len);
    check("first_byte", 16'h005A, 16'(first_byte));
    check("response_grant", 16'h0, 16'(response_grant));
    $display("test_response done");
  endtask : test_response

  // No grant may leave idle while the MAC holds ready_n high.
  task test_stall();
    base = frame_count;
    accept_stall = 1'h1;
    step(3);
    resp_request = 1'h1;
    step(1);
    resp_request = 1'h0;
    step(30);
    check("response_grant", 16'h0, 16'(response_grant));
    accept_stall = 1'h0;
    wait_frames(base + 16'h1, 400);
    step(20);
    $display("test_stall done");
  endtask : test_stall

  // Both sources pending at once, FIFO overfilled, then a full group.
  task test_priority();
    base = frame_count;
    accept_stall = 1'h1;
    stream_enable = 1'h1;
    sample_strobe = 1'h1;
    step(1100);
    check("fifo_full", 16'h1, 16'(fifo_level_flags[1]));
    resp_request = 1'h1;
    step(1);
    resp_request = 1'h0;
    step(3);
    accept_stall = 1'h0;
    for (int i = 0; i < 20 && !(response_grant || stream_grant); i++)
      step(1);
    check("response_first", 16'h1, 16'(response_grant));
    for (int i = 0; i < 6000 && stream_group_done !== 1'h1; i++)
      step(1);
    check("group_done", 16'h1, 16'(stream_group_done));
    stream_enable = 1'h0;
    sample_strobe = 1'h0;
    step(40);
    check("frame_count", base + 16'h5, frame_count);
    check("last_frame_len", 16'h022D, last_frame_len);
    check("stream_grant", 16'h0, 16'(stream_grant));
    check("stream_first_byte", 16'h00AA, 16'(first_byte));
    flag_clear = 1'h1;
    step(1);
    flag_clear = 1'h0;
    step(1);
    check("flags", 16'h0, 16'({illegal_state_flag, fifo_level_flags}));
    $display("test_priority done");
  endtask : test_priority

  // Streaming left on across a group end: the grant must stay away for
  // the whole pause, then come back for a second group.
  task test_pause();
    int n;
    base = frame_count;
    stream_enable = 1'h1;
    sample_strobe = 1'h1;
    for (n = 0; n < 6000 && stream_group_done !== 1'h1; n++)
      step(1);
    step(1);
    for (n = 0; n < 100 && stream_grant !== 1'h1; n++)
      step(1);
    check("pause_cycles", 16'(`ETA_STRM_PAUSE_CYC), 16'(n));
    for (n = 0; n < 6000 && stream_group_done !== 1'h1; n++)
      step(1);
    stream_enable = 1'h0;
    sample_strobe = 1'h0;
    step(40);
    check("frame_count", base + 16'h8, frame_count);
    $display("test_pause done");
  endtask : test_pause

  // ==========================================================================
  // Main sequence: reset held for 16 cycles, then each scenario in turn.
  initial
  begin
    step(16);
    rst_n = 1'h1;
    step(2);
    test_reset();
    test_response();
    test_stall();
    test_priority();
    test_pause();
    finish_test();
  end

  // Watchdog well beyond the roughly 8200 cycles the scenarios need.
  initial
  begin
    step(30000);
    $display("FAIL watchdog expected done seen timeout");
    fails++;
    finish_test();
  end

endmodule : eta_egress_arbiter_test

`default_nettype wire
